//--- common/arct_pkg.sv
// Overview of operation
// - Burst average mode 011 retriggers sampling until count reaches repeat target.
// - Low-pass mode 100 accumulates until count reaches target, then compares.
// - In low-pass mode the count never auto-resets; software clears it.
// - In low-pass mode shift select sets filter time constant 2^n, gain 1:1.
// - Conversion results are latched at end of conversion and held.
// - Calculation select picks one of six difference calculations.
// - Difference is compared to upper and lower thresholds, setting both flags.
// - Threshold mode selects one of eight trigger conditions.
// - A met threshold condition sets the threshold interrupt flag.
// - Threshold comparisons are signed two's complement.
// - Sum overflow always signals a threshold interrupt.
// - Prior input select 1 uses filtered value captured at start of conversion.
// - Sum clear command clears sum, overflow, count; hardware then drops the bit.
package arct_pkg;
   localparam int DATA_W = 12;
   localparam int SUM_W = 18;
   localparam int TH_W = 16;
   localparam int CNT_W = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CFG = 8'h04;
   localparam logic [7:0] ADDR_RPT = 8'h08;
   localparam logic [7:0] ADDR_UTH = 8'h0c;
   localparam logic [7:0] ADDR_LTH = 8'h10;
   localparam logic [7:0] ADDR_SETP = 8'h14;
   localparam logic [7:0] ADDR_RES = 8'h18;
   localparam logic [7:0] ADDR_SUM = 8'h1c;
   localparam logic [7:0] ADDR_FLT = 8'h20;
   localparam logic [7:0] ADDR_ERR = 8'h24;
   localparam logic [7:0] ADDR_STAT = 8'h28;
   localparam logic [7:0] ADDR_IRQ = 8'h2c;
   localparam logic [7:0] ADDR_MASK = 8'h30;
   localparam int CTRL_PRIOR_INPUT_SELECT = 7;
   localparam int CTRL_SUM_CLEAR_COMMAND = 3;
   localparam int CFG_CONT = 7;
   localparam int STAT_UTHR = 8;
   localparam int STAT_LTHR = 9;
   localparam int STAT_OV = 10;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [CNT_W-1:0] RPT_RST = 8'h00;
   localparam logic [TH_W-1:0] TH_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
   typedef enum logic [2:0] {MD_BASIC = 3'h0, MD_ACCUM = 3'h1, MD_AVG = 3'h2, MD_BURST = 3'h3,
      MD_LPF = 3'h4} arct_mode_e;
   typedef enum logic [2:0] {CALC_DIFF = 3'h0, CALC_CAP = 3'h1, CALC_SETP = 3'h2, CALC_RFLT = 3'h3,
      CALC_DFLT = 3'h4, CALC_FSETP = 3'h5} arct_calc_e;
   typedef enum logic [2:0] {TM_NEVER = 3'h0, TM_LT_LO = 3'h1, TM_GE_LO = 3'h2, TM_INSIDE = 3'h3,
      TM_OUTSIDE = 3'h4, TM_LE_UP = 3'h5, TM_GT_UP = 3'h6, TM_ALWAYS = 3'h7} arct_tmode_e;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SUM = 2'b01, ST_CALC = 2'b11, ST_CMP = 2'b10} arct_state_e;
endpackage

//--- common/arct_thr_if.sv
`timescale 1ns/100ps
interface arct_thr_if;
   import arct_pkg::*;
   logic signed [TH_W-1:0] err;
   logic signed [TH_W-1:0] upper_threshold;
   logic signed [TH_W-1:0] lower_threshold;
   logic [2:0] tmode;
   logic ov;
   logic uthr;
   logic lthr;
   logic hit;
   modport main (output err, upper_threshold, lower_threshold, tmode, ov, input uthr, lthr, hit);
   modport thr (input err, upper_threshold, lower_threshold, tmode, ov, output uthr, lthr, hit);
endinterface

//--- rtl/arct_thr_cmp.sv
`timescale 1ns/100ps
module arct_thr_cmp
   import arct_pkg::*;
(
   // Compare operands and results
   arct_thr_if.thr t
);
   logic below_lo;
   logic above_up;
   always_comb begin
      below_lo = t.err < t.lower_threshold;
      above_up = t.err > t.upper_threshold;
      t.uthr = above_up;
      t.lthr = below_lo;
      unique case (t.tmode)
         TM_NEVER: t.hit = 1'b0;
         TM_LT_LO: t.hit = below_lo;
         TM_GE_LO: t.hit = ~below_lo;
         TM_INSIDE: t.hit = ~below_lo & ~above_up;
         TM_OUTSIDE: t.hit = below_lo | above_up;
         TM_LE_UP: t.hit = ~above_up;
         TM_GT_UP: t.hit = above_up;
         TM_ALWAYS: t.hit = 1'b1;
      endcase
      t.hit = t.hit | t.ov;
   end
endmodule

//--- rtl/arct_compute.sv
`timescale 1ns/100ps
module arct_compute
   import arct_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Converter events
   input wire logic conv_start_i,
   input wire logic conv_done_i,
   input wire logic [DATA_W-1:0] conv_data_i,
   output logic retrigger_o,
   // Interrupt
   output logic irq_o
);
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [7:0] ctrl;
      logic [7:0] cfg;
      logic [CNT_W-1:0] repeat_target;
      logic [TH_W-1:0] upper_threshold;
      logic [TH_W-1:0] lower_threshold;
      logic [TH_W-1:0] setp;
      logic [TH_W-1:0] result;
      logic [TH_W-1:0] prev;
      logic [TH_W-1:0] flt;
      logic [TH_W-1:0] flt_prev;
      logic [TH_W-1:0] flt_soc;
      logic [SUM_W-1:0] sum;
      logic ov;
      logic [CNT_W-1:0] cnt;
      logic [TH_W-1:0] err;
      logic uthr;
      logic lthr;
      logic tif;
      logic mask;
      logic irq;
      logic retrig;
      arct_state_e st;
   } arct_state_s;

   arct_state_s s_r;
   arct_state_s s_nxt;
   arct_thr_if thr_if ();

   arct_thr_cmp u_thr (
      .t(thr_if)
   );

   assign thr_if.err = s_r.err;
   assign thr_if.upper_threshold = s_r.upper_threshold;
   assign thr_if.lower_threshold = s_r.lower_threshold;
   assign thr_if.tmode = s_r.cfg[6:4];
   assign thr_if.ov = s_r.ov;

   always_comb begin
      logic [31:0] rd;
      logic mapped;
      logic access;
      logic wr;
      logic set_tif;
      logic go;
      logic [SUM_W:0] wide;
      logic [SUM_W-1:0] shifted;
      logic [2:0] crs;
      arct_mode_e md;
      rd = 32'h0000_0000;
      mapped = 1'b1;
      access = psel_i & penable_i & ~s_r.pready;
      wr = psel_i & penable_i & s_r.pready & pwrite_i;
      set_tif = 1'b0;
      go = 1'b0;
      wide = '0;
      shifted = '0;
      crs = s_r.ctrl[6:4];
      md = arct_mode_e'(s_r.ctrl[2:0]);
      s_nxt = s_r;
      s_nxt.retrig = 1'b0;

      // Read decode
      unique case (paddr_i)
         ADDR_CTRL: rd[7:0] = s_r.ctrl;
         ADDR_CFG: rd[7:0] = s_r.cfg;
         ADDR_RPT: rd[CNT_W-1:0] = s_r.repeat_target;
         ADDR_UTH: rd[TH_W-1:0] = s_r.upper_threshold;
         ADDR_LTH: rd[TH_W-1:0] = s_r.lower_threshold;
         ADDR_SETP: rd[TH_W-1:0] = s_r.setp;
         ADDR_RES: rd[TH_W-1:0] = s_r.result;
         ADDR_SUM: rd[SUM_W-1:0] = s_r.sum;
         ADDR_FLT: rd[TH_W-1:0] = s_r.flt;
         ADDR_ERR: rd[TH_W-1:0] = s_r.err;
         ADDR_STAT: rd[10:0] = {s_r.ov, s_r.lthr, s_r.uthr, s_r.cnt};
         ADDR_IRQ: rd[0] = s_r.tif;
         ADDR_MASK: rd[0] = s_r.mask;
         default: mapped = 1'b0;
      endcase

      // APB answer one cycle into the access phase
      s_nxt.pready = access;
      s_nxt.pslverr = access & ~mapped;
      if (access) begin
         s_nxt.prdata = rd;
      end

      // Conversion flow
      if (conv_start_i) begin
         s_nxt.flt_soc = s_r.flt;
      end
      unique case (s_r.st)
         ST_IDLE: begin
            if (s_r.ctrl[CTRL_SUM_CLEAR_COMMAND]) begin
               s_nxt.sum = '0;
               s_nxt.ov = 1'b0;
               s_nxt.cnt = '0;
               s_nxt.ctrl[CTRL_SUM_CLEAR_COMMAND] = 1'b0;
            end else if (conv_done_i) begin
               s_nxt.result = TH_W'(conv_data_i);
               s_nxt.prev = s_r.ctrl[CTRL_PRIOR_INPUT_SELECT] ? s_r.flt_soc : s_r.result;
               s_nxt.flt_prev = s_r.flt;
               if (md != MD_BASIC) begin
                  if (md == MD_LPF) begin
                     wide = {1'b0, s_r.sum - (s_r.sum >> crs)} + (SUM_W + 1)'(conv_data_i);
                  end else begin
                     wide = {1'b0, s_r.sum} + (SUM_W + 1)'(conv_data_i);
                  end
                  s_nxt.sum = wide[SUM_W-1:0];
                  s_nxt.ov = s_r.ov | wide[SUM_W];
                  if (s_r.cnt != CNT_MAX) begin
                     s_nxt.cnt = s_r.cnt + 1'b1;
                  end
               end
               s_nxt.st = ST_SUM;
            end
         end
         ST_SUM: begin
            shifted = s_r.sum >> crs;
            if (md == MD_BASIC) begin
               go = 1'b1;
            end else begin
               s_nxt.flt = shifted[TH_W-1:0];
               go = s_r.cnt >= s_r.repeat_target;
            end
            if (go && (md == MD_AVG || md == MD_BURST)) begin
               s_nxt.sum = '0;
               s_nxt.cnt = '0;
            end
            if (!go && md == MD_BURST) begin
               s_nxt.retrig = 1'b1;
            end
            s_nxt.st = go ? ST_CALC : ST_IDLE;
         end
         ST_CALC: begin
            unique case (s_r.cfg[2:0])
               CALC_DIFF: s_nxt.err = s_r.result - s_r.prev;
               CALC_CAP: s_nxt.err = s_r.prev - s_r.result;
               CALC_SETP: s_nxt.err = s_r.result - s_r.setp;
               CALC_RFLT: s_nxt.err = s_r.result - s_r.flt;
               CALC_DFLT: s_nxt.err = s_r.flt - s_r.flt_prev;
               CALC_FSETP: s_nxt.err = s_r.flt - s_r.setp;
               default: s_nxt.err = '0;
            endcase
            s_nxt.st = ST_CMP;
         end
         ST_CMP: begin
            s_nxt.uthr = thr_if.uthr;
            s_nxt.lthr = thr_if.lthr;
            set_tif = thr_if.hit;
            s_nxt.retrig = s_r.cfg[CFG_CONT];
            s_nxt.st = ST_IDLE;
         end
      endcase

      // Register writes
      if (wr) begin
         unique case (paddr_i)
            ADDR_CTRL: s_nxt.ctrl = pwdata_i[7:0] | {4'h0, s_nxt.ctrl[CTRL_SUM_CLEAR_COMMAND], 3'h0};
            ADDR_CFG: s_nxt.cfg = pwdata_i[7:0];
            ADDR_RPT: s_nxt.repeat_target = pwdata_i[CNT_W-1:0];
            ADDR_UTH: s_nxt.upper_threshold = pwdata_i[TH_W-1:0];
            ADDR_LTH: s_nxt.lower_threshold = pwdata_i[TH_W-1:0];
            ADDR_SETP: s_nxt.setp = pwdata_i[TH_W-1:0];
            ADDR_IRQ: s_nxt.tif = s_r.tif & ~pwdata_i[0];
            ADDR_MASK: s_nxt.mask = pwdata_i[0];
            default: ;
         endcase
      end
      if (set_tif) begin
         s_nxt.tif = 1'b1;
      end
      s_nxt.irq = s_nxt.tif & s_nxt.mask;
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         s_r <= '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000, ctrl: CTRL_RST, cfg: CFG_RST,
            repeat_target: RPT_RST, upper_threshold: TH_RST, lower_threshold: TH_RST, setp: TH_RST, result: TH_RST, prev: TH_RST,
            flt: TH_RST, flt_prev: TH_RST, flt_soc: TH_RST, sum: '0, ov: 1'b0, cnt: '0, err: TH_RST,
            uthr: 1'b0, lthr: 1'b0, tif: 1'b0, mask: 1'b0, irq: 1'b0, retrig: 1'b0, st: ST_IDLE};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata_o = s_r.prdata;
   assign pready_o = s_r.pready;
   assign pslverr_o = s_r.pslverr;
   assign retrigger_o = s_r.retrig;
   assign irq_o = s_r.irq;
endmodule

//--- verif/arct_compute_assertions.sv
`timescale 1ns/100ps
module arct_compute_assertions
   import arct_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // APB
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // Converter and interrupt
   input wire logic conv_start_i,
   input wire logic conv_done_i,
   input wire logic [DATA_W-1:0] conv_data_i,
   input wire logic retrigger_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   ready_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o) else $error("late ready");
   ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready too long");
   ready_access_a: assert property (pready_o |-> psel_i && penable_i) else $error("ready outside access");
   slverr_qual_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
   refused_data_a: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0) else $error("refused data");
   rdata_hold_a: assert property (!(psel_i && penable_i) |=> $stable(prdata_o)) else $error("read data moved");
   retrig_pulse_a: assert property (retrigger_o |=> !retrigger_o) else $error("long retrigger");
   retrig_cause_a: assert property (retrigger_o |-> $past(conv_done_i, 2) || $past(conv_done_i, 4))
      else $error("retrigger without sample");
   irq_rise_a: assert property ($rose(irq_o) |-> $past(conv_done_i, 4) || $past(pready_o))
      else $error("interrupt without compare");
endmodule

//--- verif/arct_conv_model.sv
`timescale 1ns/100ps
module arct_conv_model
   import arct_pkg::*;
(
   // Clock and requests
   input wire logic clk_i,
   input wire logic kick_i,
   input wire logic retrigger_i,
   input wire logic [DATA_W-1:0] sample_i,
   // Converter events
   output logic start_o = 1'b0,
   output logic done_o = 1'b0,
   output logic [DATA_W-1:0] data_o = '0
);
   int n = 0;
   // Data goes stale after the done pulse, conversions spaced at least 5 cycles
   always @(posedge clk_i) begin
      start_o <= 1'b0;
      done_o <= 1'b0;
      if (done_o) data_o <= ~data_o;
      if (n == 1) begin
         done_o <= 1'b1;
         data_o <= sample_i;
      end
      if (n > 0) n <= n - 1;
      else if (kick_i || retrigger_i) begin
         start_o <= 1'b1;
         n <= 5 + $urandom_range(3);
      end
   end
endmodule

//--- verif/testbench.sv
`timescale 1ns/100ps
module testbench
   import arct_pkg::*;
;
   logic clk_i = 0, resetn_i = 0, psel = 0, penable = 0, pwrite = 0, kick = 0, qe;
   logic pready, pslverr, cstart, cdone, retrig, irq;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, q;
   logic [DATA_W-1:0] smp = 0, cdata;
   logic [DATA_W-1:0] cs[4] = '{12'd1947, 12'd1948, 12'd2148, 12'd2149};
   logic [7:0] ra[9] = '{ADDR_CTRL, ADDR_CFG, ADDR_RPT, ADDR_UTH, ADDR_LTH, ADDR_SETP, ADDR_STAT, ADDR_IRQ, ADDR_MASK};
   int err_count = 0, checks = 0, cyc = 0, rc = 0;
   always #2.5 clk_i = ~clk_i;
   arct_compute dut (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .conv_start_i(cstart), .conv_done_i(cdone), .conv_data_i(cdata), .retrigger_o(retrig), .irq_o(irq));
   arct_conv_model cm (.clk_i(clk_i), .kick_i(kick), .retrigger_i(retrig), .sample_i(smp), .start_o(cstart),
      .done_o(cdone), .data_o(cdata));
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (retrig === 1'b1) rc <= rc + 1;
      if (cyc == 20000) begin
         err_count++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1;
      do @(posedge clk_i); while (pready !== 1'b1);
      q = prdata;
      qe = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk_i);
   endtask
   task automatic conv(input logic [DATA_W-1:0] s, input int k);
      smp <= s;
      kick <= 1;
      @(posedge clk_i);
      kick <= 0;
      repeat (k) do @(posedge clk_i); while (cdone !== 1'b1);
      repeat (6) @(posedge clk_i);
   endtask
   // Mode write with sum clear, then poll until the clear bit drops
   task automatic sclr(input logic [7:0] c);
      apb(1, ADDR_CTRL, {24'h0, c | 8'h08});
      do apb(0, ADDR_CTRL, 0); while (q[CTRL_SUM_CLEAR_COMMAND] !== 1'b0);
   endtask
   function automatic logic hit(input logic [2:0] m, input int e);
      case (m)
         3'h0: return 0;
         3'h1: return e < -100;
         3'h2: return e >= -100;
         3'h3: return e >= -100 && e <= 100;
         3'h4: return e < -100 || e > 100;
         3'h5: return e <= 100;
         3'h6: return e > 100;
         default: return 1;
      endcase
   endfunction
   // Expected difference for each calculation select in accumulate mode with no shift
   function automatic int calc(input logic [2:0] c, input int r, input int p, input int f);
      case (c)
         3'h0: return r - p;
         3'h1: return p - r;
         3'h2: return r - 2048;
         3'h3: return r - f;
         3'h4: return r;
         3'h5: return f - 2048;
         default: return 0;
      endcase
   endfunction
   initial begin
      logic [DATA_W-1:0] s;
      int e, sm, p, r0;
      void'($urandom(17985));
      repeat (16) @(posedge clk_i);
      resetn_i <= 1;
      @(posedge clk_i);
      foreach (ra[i]) begin
         apb(0, ra[i], 0);
         chk("reset value", 0, q);
      end
      apb(0, 8'h34, 0);
      chk("unmapped data", 0, q);
      chk("unmapped error", 1, qe);
      apb(1, ADDR_UTH, 32'h64);
      apb(1, ADDR_LTH, 32'hff9c);
      apb(1, ADDR_SETP, 32'h800);
      sclr({1'b0, 3'h0, 1'b0, MD_BASIC});
      for (int i = 0; i < 16; i++) begin
         s = i[3] ? DATA_W'($urandom) : cs[i[1:0]];
         apb(1, ADDR_CFG, {24'h0, 1'b0, i[2:0], 1'b0, CALC_SETP});
         apb(1, ADDR_MASK, {31'h0, i < 8});
         conv(s, 1);
         e = int'(s) - 2048;
         apb(0, ADDR_ERR, 0);
         chk("error", {16'h0, 16'(e)}, q);
         apb(0, ADDR_STAT, 0);
         chk("flags", 32'({e < -100, e > 100}) << 8, q & 32'h300);
         apb(0, ADDR_IRQ, 0);
         chk("tif", hit(i[2:0], e), q[0]);
         chk("irq", hit(i[2:0], e) && i < 8, irq);
         apb(1, ADDR_IRQ, 1);
      end
      apb(1, ADDR_RPT, 4);
      sclr({1'b0, 3'h2, 1'b0, MD_BURST});
      r0 = rc;
      conv(12'h9a5, 4);
      chk("retriggers", 3, rc - r0);
      apb(0, ADDR_FLT, 0);
      chk("average", 12'h9a5, q);
      apb(1, ADDR_RPT, 2);
      sclr({1'b0, 3'h1, 1'b0, MD_LPF});
      sm = 0;
      for (int i = 0; i < 4; i++) begin
         s = DATA_W'($urandom);
         sm = sm + s - (sm >> 1);
         conv(s, 1);
      end
      apb(0, ADDR_STAT, 0);
      chk("count", 4, q[7:0]);
      apb(0, ADDR_FLT, 0);
      chk("filtered", sm >> 1, q);
      // Accumulate mode, every calculation select in turn
      apb(1, ADDR_RPT, 0);
      sclr({1'b0, 3'h0, 1'b0, MD_ACCUM});
      sm = 0;
      p = int'(s);
      for (int i = 0; i < 8; i++) begin
         s = DATA_W'($urandom);
         sm = sm + int'(s);
         apb(1, ADDR_CFG, {24'h0, 5'h00, i[2:0]});
         conv(s, 1);
         apb(0, ADDR_ERR, 0);
         chk("calc", {16'h0, 16'(calc(i[2:0], s, p, sm))}, q);
         p = int'(s);
      end
      // Prior input taken from the filtered value at start of conversion
      apb(1, ADDR_CTRL, {24'h0, 1'b1, 3'h0, 1'b0, MD_ACCUM});
      apb(1, ADDR_CFG, 32'h0);
      s = DATA_W'($urandom);
      conv(s, 1);
      apb(0, ADDR_ERR, 0);
      chk("prior filtered", {16'h0, 16'(int'(s) - sm)}, q);
      // Continuous sampling until the sum overflows, threshold mode never
      r0 = rc;
      apb(1, ADDR_CFG, 32'h80);
      apb(1, ADDR_IRQ, 1);
      conv(12'hfff, 64);
      apb(1, ADDR_CFG, 32'h0);
      repeat (16) @(posedge clk_i);
      chk("continuous", 64, rc - r0);
      apb(0, ADDR_STAT, 0);
      chk("overflow", 1, q[STAT_OV]);
      apb(0, ADDR_IRQ, 0);
      chk("overflow tif", 1, q[0]);
      sclr({1'b0, 3'h1, 1'b0, MD_LPF});
      apb(0, ADDR_STAT, 0);
      chk("cleared count", 0, q[7:0]);
      chk("cleared overflow", 0, q[STAT_OV]);
      apb(0, ADDR_SUM, 0);
      chk("cleared sum", 0, q);
      complete_run();
   end
endmodule
bind arct_compute arct_compute_assertions chk_u (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .conv_start_i(conv_start_i), .conv_done_i(conv_done_i),
   .conv_data_i(conv_data_i), .retrigger_o(retrigger_o), .irq_o(irq_o));
